// file: rtl/bbr_pkg.sv
// Package of constants and types for the bit, branch and rotate executor
// Operation
// RL1 - Bit clear zeroes selected file bit only
// RL2 - Bit set writes one to selected bit
// RL3 - Skip-if-zero discards next instruction when bit clear
// RL4 - Skip-if-one discards next instruction when bit set
// RL5 - Relative branch adds signed 9-bit literal
// RL6 - Branch by W adds unsigned W
// RL7 - Return with literal loads W, pops stack
// RL8 - Plain return pops stack, flags unchanged
// RL9 - Rotate left through carry, one cycle
// RL10 - Destination zero to W, one to file
// RL11 - Rotate right through carry, same destination select
// RL12 - Bit clear/set single cycle read-modify-write
`default_nettype none
package bbr_pkg;
  localparam int PC_W   = 15;
  localparam int FA_W   = 7;
  localparam int PC_RST = 0;
  localparam logic [3:0] DEST_W    = 4'h0;
  localparam int         CYC_ONE   = 1;
  localparam int         CYC_TWO   = 2;

  typedef enum logic [3:0] {
    BBR_OP_NOP  = 4'h0,
    BBR_OP_BCLR = 4'h1,
    BBR_OP_BSET = 4'h2,
    BBR_OP_TSZ  = 4'h3,
    BBR_OP_TSO  = 4'h4,
    BBR_OP_RBR  = 4'h5,
    BBR_OP_BWR  = 4'h6,
    BBR_OP_RLIT = 4'h7,
    BBR_OP_RET  = 4'h8,
    BBR_OP_RLC  = 4'h9,
    BBR_OP_RRC  = 4'ha
  } bbr_op_t;

  typedef struct packed {
    bbr_op_t         op;
    logic [FA_W-1:0] faddr;
    logic [2:0]      bsel;
    logic            dest;
    logic [8:0]      lit;
  } bbr_instr_t;

  typedef struct packed {
    logic            we;
    logic [FA_W-1:0] addr;
    logic [7:0]      data;
  } bbr_fwr_t;
endpackage : bbr_pkg
`default_nettype wire

// file: rtl/bbr_alu.sv
// Combinational bit and rotate unit
`timescale 1ns/10ps
`default_nettype none
module bbr_alu
  import bbr_pkg::*;
(
  input  wire bbr_op_t    op,       // Operation
  input  wire logic [7:0] fval,     // File register value
  input  wire logic [2:0] bsel,     // Bit select
  input  wire logic       cin,      // Carry in
  output logic      [7:0] res,      // Result
  output logic            cout,     // Carry out
  output logic            tbit      // Tested bit
);
  always_comb begin
    res  = fval;
    cout = cin;
    tbit = fval[bsel];
    case (op)
      BBR_OP_BCLR: res[bsel] = 1'b0; // see RL1
      BBR_OP_BSET: res[bsel] = 1'b1; // see RL2
      BBR_OP_RLC: begin
        res  = {fval[6:0], cin}; // see RL9
        cout = fval[7];
      end
      BBR_OP_RRC: begin
        res  = {cin, fval[7:1]}; // see RL11
        cout = fval[0];
      end
      default: res = fval;
    endcase
  end
endmodule // bbr_alu
`default_nettype wire

// file: rtl/bbr_exec.sv
// Execution core for bit, branch, return and rotate instructions
`timescale 1ns/10ps
`default_nettype none
module bbr_exec
  import bbr_pkg::*;
(
  input  wire logic              core_clk,    // Core clock
  input  wire logic              reset_n,     // Async reset, active low
  input  wire logic              instr_vld,   // Instruction presented
  input  wire bbr_instr_t        instr,       // Decoded instruction
  input  wire logic [PC_W-1:0]   pc_inc,      // Incremented program counter
  input  wire logic [7:0]        file_rdata,  // Addressed file register value
  input  wire logic [PC_W-1:0]   stack_top,   // Return stack top entry
  input  wire logic              carry_in,    // Current carry flag
  input  wire logic [7:0]        wreg_in,     // Current working register
  output bbr_fwr_t               file_wr,     // File write port
  output logic                   wreg_we,     // Working register load
  output logic [7:0]             wreg_out,    // Working register value
  output logic                   carry_we,    // Carry flag load
  output logic                   carry_out,   // Carry flag value
  output logic                   pc_load,     // Program counter load
  output logic [PC_W-1:0]        pc_target,   // New program counter
  output logic                   stack_pop,   // Pop return stack
  output logic                   flush,       // Discard next instruction
  output logic                   busy         // Second cycle, fetch held
);
  typedef enum logic [0:0] {
    BBR_ST_RUN  = 1'b0,
    BBR_ST_WAIT = 1'b1
  } bbr_st_t;

  bbr_st_t         st_q, st_d;
  bbr_fwr_t        fwr_q, fwr_d;
  logic            wwe_q, wwe_d, cwe_q, cwe_d, c_q, c_d;
  logic [7:0]      w_q, w_d;
  logic            pl_q, pl_d, pop_q, pop_d, fl_q, fl_d;
  logic [PC_W-1:0] pt_q, pt_d;
  logic [7:0]      alu_res;
  logic            alu_c, tbit;
  logic            take;

  bbr_alu u_alu (
    .op   (instr.op),
    .fval (file_rdata),
    .bsel (instr.bsel),
    .cin  (carry_in),
    .res  (alu_res),
    .cout (alu_c),
    .tbit (tbit)
  );

  assign take = instr_vld && (st_q == BBR_ST_RUN);

  always_comb begin
    st_d  = BBR_ST_RUN;
    fwr_d = '{we: 1'b0, addr: instr.faddr, data: alu_res};
    wwe_d = 1'b0;
    w_d   = w_q;
    cwe_d = 1'b0;
    c_d   = c_q;
    pl_d  = 1'b0;
    pt_d  = pt_q;
    pop_d = 1'b0;
    fl_d  = 1'b0;
    if (take) begin
      case (instr.op)
        BBR_OP_BCLR, BBR_OP_BSET: begin
          fwr_d.we = 1'b1; // see RL12
        end
        BBR_OP_TSZ: begin
          if (!tbit) begin
            fl_d = 1'b1; // see RL3
            st_d = BBR_ST_WAIT;
          end
        end
        BBR_OP_TSO: begin
          if (tbit) begin
            fl_d = 1'b1; // see RL4
            st_d = BBR_ST_WAIT;
          end
        end
        BBR_OP_RBR: begin
          pl_d = 1'b1;
          pt_d = PC_W'(pc_inc + PC_W'($signed(instr.lit))); // see RL5
          st_d = BBR_ST_WAIT;
        end
        BBR_OP_BWR: begin
          pl_d = 1'b1;
          pt_d = PC_W'(pc_inc + {{(PC_W-8){1'b0}}, wreg_in}); // see RL6
          st_d = BBR_ST_WAIT;
        end
        BBR_OP_RLIT: begin
          wwe_d = 1'b1;
          w_d   = instr.lit[7:0]; // see RL7
          pl_d  = 1'b1;
          pt_d  = stack_top;
          pop_d = 1'b1;
          st_d  = BBR_ST_WAIT;
        end
        BBR_OP_RET: begin
          pl_d  = 1'b1;
          pt_d  = stack_top; // see RL8
          pop_d = 1'b1;
          st_d  = BBR_ST_WAIT;
        end
        BBR_OP_RLC, BBR_OP_RRC: begin
          cwe_d = 1'b1; // see RL9
          c_d   = alu_c;
          if (instr.dest == DEST_W[0]) begin
            wwe_d = 1'b1; // see RL10
            w_d   = alu_res;
          end else begin
            fwr_d.we = 1'b1; // see RL11
          end
        end
        default: st_d = BBR_ST_RUN;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q  <= BBR_ST_RUN;
      fwr_q <= '0;
      wwe_q <= 1'b0;
      w_q   <= 8'h00;
      cwe_q <= 1'b0;
      c_q   <= 1'b0;
      pl_q  <= 1'b0;
      pt_q  <= PC_W'(PC_RST);
      pop_q <= 1'b0;
      fl_q  <= 1'b0;
    end else begin
      st_q  <= st_d;
      fwr_q <= fwr_d;
      wwe_q <= wwe_d;
      w_q   <= w_d;
      cwe_q <= cwe_d;
      c_q   <= c_d;
      pl_q  <= pl_d;
      pt_q  <= pt_d;
      pop_q <= pop_d;
      fl_q  <= fl_d;
    end
  end

  assign file_wr   = fwr_q;
  assign wreg_we   = wwe_q;
  assign wreg_out  = w_q;
  assign carry_we  = cwe_q;
  assign carry_out = c_q;
  assign pc_load   = pl_q;
  assign pc_target = pt_q;
  assign stack_pop = pop_q;
  assign flush     = fl_q;
  assign busy      = (st_q == BBR_ST_WAIT);

  a_bit_clear: assert property (@(posedge core_clk) disable iff (!reset_n) // see RL1
    take && instr.op == BBR_OP_BCLR |=> file_wr.we && !file_wr.data[$past(instr.bsel)]
      && !carry_we && !wreg_we)
    else $error("bit clear wrong");
  a_bit_set: assert property (@(posedge core_clk) disable iff (!reset_n) // see RL2
    take && instr.op == BBR_OP_BSET |=> file_wr.data[$past(instr.bsel)] && !carry_we)
    else $error("bit set wrong");
  a_skip_zero: assert property (@(posedge core_clk) disable iff (!reset_n) // see RL3
    take && instr.op == BBR_OP_TSZ |=> flush == !$past(file_rdata[instr.bsel]))
    else $error("skip if zero wrong");
  a_skip_one: assert property (@(posedge core_clk) disable iff (!reset_n) // see RL4
    take && instr.op == BBR_OP_TSO |=> flush == $past(file_rdata[instr.bsel]))
    else $error("skip if one wrong");
  a_rel_branch: assert property (@(posedge core_clk) disable iff (!reset_n) // see RL5
    take && instr.op == BBR_OP_RBR |=> pc_load && busy
      && pc_target == PC_W'($past(pc_inc) + PC_W'($signed($past(instr.lit)))) ##1 !busy)
    else $error("relative branch wrong");
  a_w_branch: assert property (@(posedge core_clk) disable iff (!reset_n) // see RL6
    take && instr.op == BBR_OP_BWR |=> pc_load && !carry_we
      && pc_target == PC_W'($past(pc_inc) + {7'h00, $past(wreg_in)}))
    else $error("branch by w wrong");
  a_ret_lit: assert property (@(posedge core_clk) disable iff (!reset_n) // see RL7
    take && instr.op == BBR_OP_RLIT |=> wreg_we && stack_pop && busy
      && wreg_out == $past(instr.lit[7:0]) && pc_target == $past(stack_top))
    else $error("return with literal wrong");
  a_ret_plain: assert property (@(posedge core_clk) disable iff (!reset_n) // see RL8
    take && instr.op == BBR_OP_RET |=> stack_pop && !carry_we && !wreg_we
      && pc_target == $past(stack_top))
    else $error("return wrong");
  a_rot_left: assert property (@(posedge core_clk) disable iff (!reset_n) // see RL9
    take && instr.op == BBR_OP_RLC |=> carry_we && !busy
      && carry_out == $past(file_rdata[7]))
    else $error("rotate left wrong");
  a_rot_dest: assert property (@(posedge core_clk) disable iff (!reset_n) // see RL10
    take && (instr.op == BBR_OP_RLC || instr.op == BBR_OP_RRC)
      |=> wreg_we == !$past(instr.dest) && file_wr.we == $past(instr.dest))
    else $error("rotate destination wrong");
  a_rot_right: assert property (@(posedge core_clk) disable iff (!reset_n) // see RL11
    take && instr.op == BBR_OP_RRC |=> carry_out == $past(file_rdata[0])
      && file_wr.data == {$past(carry_in), $past(file_rdata[7:1])})
    else $error("rotate right wrong");
  a_rmw_single: assert property (@(posedge core_clk) disable iff (!reset_n) // see RL12
    take && (instr.op == BBR_OP_BCLR || instr.op == BBR_OP_BSET) |=> !busy
      && file_wr.addr == $past(instr.faddr))
    else $error("bit rmw not single cycle");
  a_clear_others: assert property (@(posedge core_clk) disable iff (!reset_n) // see RL1
    take && instr.op == BBR_OP_BCLR
      |=> file_wr.data == ($past(file_rdata) & ~(8'h01 << $past(instr.bsel))))
    else $error("bit clear touched other bits");
  a_skip_quiet: assert property (@(posedge core_clk) disable iff (!reset_n) // see RL3 RL4
    take && ((instr.op == BBR_OP_TSZ && tbit) || (instr.op == BBR_OP_TSO && !tbit))
      |=> !busy && !flush && !file_wr.we && !wreg_we && !carry_we && !pc_load)
    else $error("untaken skip not quiet");
  a_rot_left_res: assert property (@(posedge core_clk) disable iff (!reset_n) // see RL9
    take && instr.op == BBR_OP_RLC
      |=> file_wr.data == {$past(file_rdata[6:0]), $past(carry_in)})
    else $error("rotate left result wrong");
  // Held cycle must refuse whatever is offered
  a_busy_ignored: assert property (@(posedge core_clk) disable iff (!reset_n) // see RL5
    busy |=> !busy && !pc_load && !stack_pop && !flush && !file_wr.we && !wreg_we
      && !carry_we)
    else $error("instruction taken while held");
endmodule // bbr_exec
`default_nettype wire

// file: dv/bbr_far_model.sv
// Far-side model: file registers, working register and carry
`timescale 1ns/10ps
`default_nettype none
module bbr_far_model
  import bbr_pkg::*;
(
  input  wire logic            core_clk,   // Core clock
  input  wire logic            reset_n,    // Async reset, active low
  input  wire logic [FA_W-1:0] faddr,      // Read address
  input  wire bbr_fwr_t        file_wr,    // File write port
  input  wire logic            wreg_we,    // W load
  input  wire logic [7:0]      wreg_out,   // W value
  input  wire logic            carry_we,   // Carry load
  input  wire logic            carry_out,  // Carry value
  output logic      [7:0]      file_rdata, // Read value
  output logic      [7:0]      wreg_in,    // W now
  output logic                 carry_in    // Carry now
);
  logic [7:0] mem [128];
  initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 91 + 163);
  assign file_rdata = mem[faddr];
  always @(posedge core_clk) if (file_wr.we) mem[file_wr.addr] <= file_wr.data;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wreg_in <= 8'h00;
      carry_in <= 1'b0;
    end else begin
      if (wreg_we) wreg_in <= wreg_out;
      if (carry_we) carry_in <= carry_out;
    end
  end
endmodule // bbr_far_model
`default_nettype wire

// file: dv/testbench.sv
// Randomised bench for the bit, branch and rotate executor
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import bbr_pkg::*;
  localparam logic [8:0] COR [4] = '{9'h100, 9'h0ff, 9'h000, 9'h1ff};
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic instr_vld = 1'b0;
  bbr_instr_t instr = '0;
  logic [PC_W-1:0] pc_inc = '0, stack_top = '0, pc_target;
  logic [7:0] file_rdata, wreg_in, wreg_out, fv, w;
  logic carry_in, wreg_we, carry_we, carry_out, pc_load, stack_pop, flush, busy, c, two;
  bbr_fwr_t file_wr;
  logic [31:0] seed = 32'h00007fce, x, y;
  logic [45:0] obs;
  int fail_count = 0, checked = 0;
  always #5 core_clk = ~core_clk;
  bbr_exec dut (.core_clk, .reset_n, .instr_vld, .instr, .pc_inc, .file_rdata, .stack_top,
    .carry_in, .wreg_in, .file_wr, .wreg_we, .wreg_out, .carry_we, .carry_out, .pc_load,
    .pc_target, .stack_pop, .flush, .busy);
  bbr_far_model far (.core_clk, .reset_n, .faddr(instr.faddr), .file_wr, .wreg_we,
    .wreg_out, .carry_we, .carry_out, .file_rdata, .wreg_in, .carry_in);
  assign obs = {file_wr, wreg_we, wreg_out, carry_we, carry_out, pc_load, pc_target,
    stack_pop, flush, busy};
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Pulses always compared, held values only when loaded
  function automatic logic [45:0] msk(input logic [45:0] e);
    return 46'h200020140007 | (e[45] ? 46'h1fffc0000000 : '0) | (e[29] ? 46'h1fe00000 : '0)
      | (e[20] ? 46'h80000 : '0) | (e[18] ? 46'h3fff8 : '0);
  endfunction
  function automatic logic [45:0] rot(input logic [7:0] r, input logic co);
    if (instr.dest) return {1'b1, instr.faddr, r, 1'b0, 8'h0, 1'b1, co, 19'h0};
    return {16'h0, 1'b1, r, 1'b1, co, 19'h0};
  endfunction
  task automatic chk(input logic [45:0] s, input logic [45:0] e);
    checked++;
    if ((s & msk(e)) !== e) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s & msk(e), e);
    end
  endtask
  task automatic finish_test();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    #60000;
    fail_count++;
    finish_test();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    #1 reset_n = 1'b1;
    for (int i = 0; i < 300; i++) begin
      x = rnd();
      y = rnd();
      instr = x[23:0];
      instr.op = bbr_op_t'(4'(1 + x[31:24] % 10));
      if (i < 4) instr = '{BBR_OP_RBR, 7'h7f, 3'h7, 1'b0, COR[i]};
      pc_inc = y[14:0];
      stack_top = y[29:15];
      instr_vld = 1'b1;
      fv = far.mem[instr.faddr];
      c = carry_in;
      w = wreg_in;
      two = instr.op inside {BBR_OP_RBR, BBR_OP_BWR, BBR_OP_RLIT, BBR_OP_RET}
        || (instr.op == BBR_OP_TSZ && !fv[instr.bsel])
        || (instr.op == BBR_OP_TSO && fv[instr.bsel]);
      @(posedge core_clk);
      #1;
      case (instr.op)
        BBR_OP_BCLR: chk(obs, {1'b1, instr.faddr, fv & ~(8'h01 << instr.bsel), 30'h0});
        BBR_OP_BSET: chk(obs, {1'b1, instr.faddr, fv | (8'h01 << instr.bsel), 30'h0});
        BBR_OP_TSZ: chk(obs, {44'h0, !fv[instr.bsel], !fv[instr.bsel]});
        BBR_OP_TSO: chk(obs, {44'h0, fv[instr.bsel], fv[instr.bsel]});
        BBR_OP_RBR: chk(obs, {27'h0, 1'b1, pc_inc + {{6{instr.lit[8]}}, instr.lit}, 3'h1});
        BBR_OP_BWR: chk(obs, {27'h0, 1'b1, pc_inc + {7'h0, w}, 3'h1});
        BBR_OP_RLIT: chk(obs, {16'h0, 1'b1, instr.lit[7:0], 3'h1, stack_top, 3'h5});
        BBR_OP_RET: chk(obs, {27'h0, 1'b1, stack_top, 3'h5});
        BBR_OP_RLC: chk(obs, rot({fv[6:0], c}, fv[7]));
        default: chk(obs, rot({c, fv[7:1]}, fv[0]));
      endcase
      // Instruction offered in the held cycle must be ignored
      instr_vld = two & y[31];
      instr.op = BBR_OP_BSET;
      @(posedge core_clk);
      #1;
      chk(obs, 46'h0);
    end
    finish_test();
  end
endmodule // testbench
`default_nettype wire
